/* File: logic/excitation_dac_control.sv */
// Excitation DAC control: APB registers, calibration lock, update divider
//
// The APB register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// Contract
// - Config bit 12 picks amplifier gain: 0 gives 2, 1 gives 0.25.
// - Converter updates at analog clock divided by config bits 8..1.
// - Analog clock is selectable: 16 MHz, 32 MHz or 32 kHz oscillator.
// - Config bit 0 enables attenuator: 0 unity gain, 1 gain 0.2.
// - Code register bits 11..0 go directly to the converter input; here they pass gain and offset trim correction first.
// - Code 0x800 is midscale, zero volts; above positive, below negative.
// - Config resets to 0x1E: divider 15, gain 2, attenuator off.
// - Code register resets to 0x800, midscale.
// - Attenuator off uses plain offset trim of active power mode.
// - Attenuator on uses attenuated offset trim of active power mode.
// - One gain trim applies for all modes and settings.
// - Trims writable only after key 0xDE87A5AF in lock register.
// - Gain trim unsigned: 0x800 none, 0x000 most negative, 0xFFF most positive.
// - Offset trims two's complement half LSB: 0x001 +half, 0xFFF -half.
module excitation_dac_control (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Analog clock enables, one pulse per oscillator cycle, from pins
  input  wire logic        aclk_hs_tick,
  input  wire logic        aclk_lp_tick,
  // Power mode: high for high speed mode, from a pin
  input  wire logic        high_speed_mode,
  // Analog path controls
  output logic [11:0]      converter_code,
  output logic             converter_load,
  output logic             amp_gain_select,
  output logic             attenuator_enable,
  output logic             hs_osc_32m,
  output logic             lp_osc_select
);
  //////////////////////////////////////////////////////////////////////////////
  logic [31:0] config_reg;
  logic [11:0] code_reg;
  logic [31:0] lock_reg;
  logic [11:0] gain_reg;
  logic [11:0] ofs_att_lp_reg;
  logic [11:0] ofs_plain_lp_reg;
  logic [11:0] ofs_att_hs_reg;
  logic [11:0] ofs_plain_hs_reg;
  logic [1:0]  clk_sel_reg;
  logic [7:0]  div_cnt_reg;
  logic [7:0]  div_cnt_next;
  logic [1:0]  hs_sync_reg;
  logic [1:0]  lp_sync_reg;
  logic [1:0]  mode_sync_reg;
  logic        hs_prev_reg;
  logic        lp_prev_reg;
  logic        aclk_edge;
  logic        tick;
  logic        wr_en;
  logic        rd_en;
  logic        unlocked;
  logic        addr_ok;
  logic [11:0] corrected;
  logic [31:0] rd_data;
  excitation_dac_pkg::dac_cfg_s  cfg;
  excitation_dac_pkg::dac_trim_s trim;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] ext12(input logic [11:0] v);
    return {20'h00000, v};
  endfunction

  // Byte-lane merge of a 12-bit register; a select on a call result is not portable
  function automatic logic [11:0] merge12(input logic [11:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
    logic [31:0] r;
    r = merge(ext12(old), nw, strb);
    return r[11:0];
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Bus decode: zero wait states, every access completes in its access cycle
  assign wr_en    = psel && penable && pwrite;
  assign rd_en    = psel && !penable && !pwrite;
  assign unlocked = (lock_reg == excitation_dac_pkg::UNLOCK_KEY);

  always_comb begin
    addr_ok = 1'b1;
    rd_data = 32'h00000000;
    unique case (paddr)
      excitation_dac_pkg::ADDR_CONFIG:       rd_data = config_reg;
      excitation_dac_pkg::ADDR_CODE:         rd_data = ext12(code_reg);
      excitation_dac_pkg::ADDR_LOCK:         rd_data = lock_reg;
      excitation_dac_pkg::ADDR_GAIN:         rd_data = ext12(gain_reg);
      excitation_dac_pkg::ADDR_OFS_ATT_LP:   rd_data = ext12(ofs_att_lp_reg);
      excitation_dac_pkg::ADDR_OFS_PLAIN_LP: rd_data = ext12(ofs_plain_lp_reg);
      excitation_dac_pkg::ADDR_OFS_ATT_HS:   rd_data = ext12(ofs_att_hs_reg);
      excitation_dac_pkg::ADDR_OFS_PLAIN_HS: rd_data = ext12(ofs_plain_hs_reg);
      excitation_dac_pkg::ADDR_CLK_SEL:      rd_data = {30'h0, clk_sel_reg};
      excitation_dac_pkg::ADDR_STATUS:       rd_data = {19'h0, unlocked, converter_code};
      default:                               addr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      if (rd_en) begin
        prdata <= rd_data;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Configuration and code registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_reg <= excitation_dac_pkg::CONFIG_RESET;
    end else if (wr_en && paddr == excitation_dac_pkg::ADDR_CONFIG) begin
      // Bits above 12 are reserved and stay zero
      config_reg <= merge(config_reg, pwdata, pstrb) & 32'h00001FFF;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      code_reg <= excitation_dac_pkg::CODE_RESET;
    end else if (wr_en && paddr == excitation_dac_pkg::ADDR_CODE) begin
      // No clamping to the usable span; software owns that
      code_reg <= merge12(code_reg, pwdata, pstrb);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_sel_reg <= excitation_dac_pkg::CLK_SEL_RESET;
    end else if (wr_en && paddr == excitation_dac_pkg::ADDR_CLK_SEL && pstrb[0]) begin
      clk_sel_reg <= (pwdata[1:0] == 2'h3) ? 2'h2 : pwdata[1:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Calibration lock and trims
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_reg <= excitation_dac_pkg::LOCK_RESET;
    end else if (wr_en && paddr == excitation_dac_pkg::ADDR_LOCK) begin
      lock_reg <= merge(lock_reg, pwdata, pstrb);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gain_reg         <= excitation_dac_pkg::GAIN_RESET;
      ofs_att_lp_reg   <= excitation_dac_pkg::OFS_RESET;
      ofs_plain_lp_reg <= excitation_dac_pkg::OFS_RESET;
      ofs_att_hs_reg   <= excitation_dac_pkg::OFS_RESET;
      ofs_plain_hs_reg <= excitation_dac_pkg::OFS_RESET;
    end else if (wr_en && unlocked) begin
      unique case (paddr)
        excitation_dac_pkg::ADDR_GAIN:
          gain_reg <= merge12(gain_reg, pwdata, pstrb);
        excitation_dac_pkg::ADDR_OFS_ATT_LP:
          ofs_att_lp_reg <= merge12(ofs_att_lp_reg, pwdata, pstrb);
        excitation_dac_pkg::ADDR_OFS_PLAIN_LP:
          ofs_plain_lp_reg <= merge12(ofs_plain_lp_reg, pwdata, pstrb);
        excitation_dac_pkg::ADDR_OFS_ATT_HS:
          ofs_att_hs_reg <= merge12(ofs_att_hs_reg, pwdata, pstrb);
        excitation_dac_pkg::ADDR_OFS_PLAIN_HS:
          ofs_plain_hs_reg <= merge12(ofs_plain_hs_reg, pwdata, pstrb);
        default: begin
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Field unpacking and trim selection
  assign cfg.amp_gain_select   = config_reg[excitation_dac_pkg::CFG_GAIN_BIT];
  assign cfg.rate_div          = config_reg[excitation_dac_pkg::CFG_RATE_MSB:
                                            excitation_dac_pkg::CFG_RATE_LSB];
  assign cfg.attenuator_enable = config_reg[excitation_dac_pkg::CFG_ATTEN_BIT];

  // Both trim fields in one process so the struct has a single driver
  always_comb begin
    trim.gain = gain_reg;
    if (cfg.attenuator_enable) begin
      trim.offset = mode_sync_reg[1] ? ofs_att_hs_reg : ofs_att_lp_reg;
    end else begin
      trim.offset = mode_sync_reg[1] ? ofs_plain_hs_reg : ofs_plain_lp_reg;
    end
  end

  dac_correct u_correct (
    .code      (code_reg),
    .trim      (trim),
    .corrected (corrected)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; only the second stage feeds edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hs_sync_reg   <= 2'h0;
      lp_sync_reg   <= 2'h0;
      mode_sync_reg <= 2'h0;
      hs_prev_reg   <= 1'b0;
      lp_prev_reg   <= 1'b0;
    end else begin
      hs_sync_reg   <= {hs_sync_reg[0], aclk_hs_tick};
      lp_sync_reg   <= {lp_sync_reg[0], aclk_lp_tick};
      mode_sync_reg <= {mode_sync_reg[0], high_speed_mode};
      hs_prev_reg   <= hs_sync_reg[1];
      lp_prev_reg   <= lp_sync_reg[1];
    end
  end

  // The 32 MHz oscillator must not exceed pclk/2 to be seen edge by edge
  assign aclk_edge = (clk_sel_reg == 2'(excitation_dac_pkg::CLK_LP_32K)) ?
                     (lp_sync_reg[1] && !lp_prev_reg) :
                     (hs_sync_reg[1] && !hs_prev_reg);

  //////////////////////////////////////////////////////////////////////////////
  // Update divider; a divider of zero is treated as one
  always_comb begin
    tick         = 1'b0;
    div_cnt_next = div_cnt_reg;
    if (aclk_edge) begin
      if (div_cnt_reg + 8'h01 >= cfg.rate_div) begin
        tick         = 1'b1;
        div_cnt_next = 8'h00;
      end else begin
        div_cnt_next = div_cnt_reg + 8'h01;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_reg <= 8'h00;
    end else begin
      div_cnt_reg <= div_cnt_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      converter_code <= excitation_dac_pkg::MIDSCALE;
      converter_load <= 1'b0;
    end else begin
      converter_load <= tick;
      if (tick) begin
        converter_code <= corrected;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      amp_gain_select   <= 1'b0;
      attenuator_enable <= 1'b0;
      hs_osc_32m        <= 1'b0;
      lp_osc_select     <= 1'b0;
    end else begin
      amp_gain_select   <= cfg.amp_gain_select;
      attenuator_enable <= cfg.attenuator_enable;
      hs_osc_32m        <= (clk_sel_reg == 2'(excitation_dac_pkg::CLK_HS_32M));
      lp_osc_select     <= (clk_sel_reg == 2'(excitation_dac_pkg::CLK_LP_32K));
    end
  end
endmodule
`default_nettype wire

/* File: logic/excitation_dac_pkg.sv */
// Package: register map, field layout, reset values and correction constants
package excitation_dac_pkg;
  localparam logic [15:0] ADDR_CONFIG       = 16'h2010;
  localparam logic [15:0] ADDR_CODE         = 16'h2048;
  localparam logic [15:0] ADDR_LOCK         = 16'h2230;
  localparam logic [15:0] ADDR_GAIN         = 16'h2260;
  localparam logic [15:0] ADDR_OFS_ATT_LP   = 16'h2264;
  localparam logic [15:0] ADDR_OFS_PLAIN_LP = 16'h2268;
  localparam logic [15:0] ADDR_OFS_ATT_HS   = 16'h22B8;
  localparam logic [15:0] ADDR_OFS_PLAIN_HS = 16'h22BC;
  localparam logic [15:0] ADDR_CLK_SEL      = 16'h2300;
  localparam logic [15:0] ADDR_STATUS       = 16'h2304;

  localparam int CFG_GAIN_BIT  = 12;
  localparam int CFG_RATE_LSB  = 1;
  localparam int CFG_RATE_MSB  = 8;
  localparam int CFG_ATTEN_BIT = 0;
  localparam int CFG_RW_MSB    = 12;

  localparam logic [31:0] CONFIG_RESET = 32'h0000001E;
  localparam logic [11:0] CODE_RESET   = 12'h800;
  localparam logic [31:0] LOCK_RESET   = 32'hDE87A5A0;
  localparam logic [31:0] UNLOCK_KEY   = 32'hDE87A5AF;
  localparam logic [11:0] GAIN_RESET   = 12'h800;
  localparam logic [11:0] OFS_RESET    = 12'h000;
  localparam logic [11:0] MIDSCALE     = 12'h800;
  localparam logic [11:0] CODE_MIN     = 12'h200;
  localparam logic [11:0] CODE_MAX     = 12'hE00;

  // Analog clock choices for the update divider
  typedef enum logic [1:0] {
    CLK_HS_16M,
    CLK_HS_32M,
    CLK_LP_32K
  } aclk_sel_e;
  localparam logic [1:0] CLK_SEL_RESET = 2'h0;

  typedef struct packed {
    logic        amp_gain_select;
    logic [7:0]  rate_div;
    logic        attenuator_enable;
  } dac_cfg_s;

  typedef struct packed {
    logic [11:0] gain;
    logic [11:0] offset;
  } dac_trim_s;
endpackage

/* File: logic/dac_correct.sv */
// Gain and offset correction of the converter code
`timescale 1ns/1ps
`default_nettype none
module dac_correct (
  // Raw code and trims
  input  wire logic [11:0]                    code,
  input  wire excitation_dac_pkg::dac_trim_s  trim,
  // Corrected code
  output logic [11:0]                         corrected
);
  logic signed [13:0] centred;
  logic signed [13:0] gain_off;
  logic signed [27:0] prod;
  logic signed [15:0] scaled;
  logic signed [16:0] sum;

  always_comb begin
    // Codes are centred on midscale so zero volts stays fixed under gain
    centred  = $signed({2'h0, code}) - $signed({2'h0, excitation_dac_pkg::MIDSCALE});
    // Unsigned gain: midscale is unity, span is about +/- one eighth
    gain_off = $signed({2'h0, trim.gain}) - $signed({2'h0, excitation_dac_pkg::MIDSCALE});
    prod     = centred * gain_off;
    scaled   = 16'(centred) + 16'(prod >>> 14);
    // Offset is in half LSB steps: round by adding one before halving
    sum      = (17'(scaled) <<< 1) + 17'($signed(trim.offset)) + 17'sh00001;
    sum      = (sum >>> 1) + $signed({5'h0, excitation_dac_pkg::MIDSCALE});
    if (sum < 0) begin
      corrected = 12'h000;
    end else if (sum > $signed(17'h00FFF)) begin
      corrected = 12'hFFF;
    end else begin
      corrected = sum[11:0];
    end
  end
endmodule
`default_nettype wire

/* File: verification/excitation_dac_control_properties.sv */
// Checker for the excitation DAC control block ports
`timescale 1ns/1ps
`default_nettype none
module excitation_dac_control_properties (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Oscillators and mode
  input wire logic        aclk_hs_tick,
  input wire logic        aclk_lp_tick,
  input wire logic        high_speed_mode,
  // Analog controls
  input wire logic [11:0] converter_code,
  input wire logic        converter_load,
  input wire logic        amp_gain_select,
  input wire logic        attenuator_enable,
  input wire logic        hs_osc_32m,
  input wire logic        lp_osc_select
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  //////////////////////////////////////////////////////////////////////////////
  // Last full-word config write, kept so the copies can be compared later
  logic wr_cfg;
  logic cfg_g;
  logic cfg_a;
  assign wr_cfg = psel && penable && pready && pwrite && pstrb == 4'hF
                  && paddr == excitation_dac_pkg::ADDR_CONFIG;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_g <= 1'b0;
      cfg_a <= 1'b0;
    end else if (wr_cfg) begin
      cfg_g <= pwdata[12];
      cfg_a <= pwdata[0];
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  a_gain_follows_cfg: assert property (wr_cfg |=> ##[0:1] amp_gain_select == cfg_g)
    else $error("amplifier gain select does not follow config");
  a_atten_follows_cfg: assert property (wr_cfg |=> ##[0:1] attenuator_enable == cfg_a)
    else $error("attenuator enable does not follow config");
  a_load_marks_change: assert property ($changed(converter_code) |-> ##[0:1] converter_load)
    else $error("converter code changed without a load pulse");
  a_load_spacing: assert property (converter_load |=> !converter_load [*2])
    else $error("load pulses closer than the oscillator allows");
  a_code_after_reset: assert property ($rose(presetn) |-> converter_code == 12'h800)
    else $error("converter code not midscale after reset");
  a_osc_exclusive: assert property (!(hs_osc_32m && lp_osc_select))
    else $error("two oscillator selects at once");
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no ready in the access phase");
  a_err_with_ready: assert property (pslverr |-> pready && penable)
    else $error("slave error outside an answer");
  c_load: cover property (converter_load);
  c_error: cover property (pslverr);
  c_lowpower: cover property (lp_osc_select && converter_load);
endmodule
bind excitation_dac_control excitation_dac_control_properties u_props (.*);
`default_nettype wire

/* File: verification/excitation_dac_control_test.sv */
// Self-checking testbench for the excitation DAC control block
`timescale 1ns/1ps
`default_nettype none
module excitation_dac_control_test;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [15:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rdat;
  logic [3:0]  pstrb = 4'hF;
  logic        pready, pslverr, rerr, converter_load, amp_gain_select, attenuator_enable;
  logic        aclk_hs_tick = 0, aclk_lp_tick = 0, high_speed_mode = 0, hs_osc_32m, lp_osc_select;
  logic [11:0] converter_code;
  int          n_mismatch = 0, tests_run = 0;
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin \
  $display("Error %s expected %0h seen %0h", nm, ex, got); n_mismatch++; end end
  excitation_dac_control u_excitation_dac_control (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .aclk_hs_tick, .aclk_lp_tick,
    .high_speed_mode, .converter_code, .converter_load, .amp_gain_select, .attenuator_enable,
    .hs_osc_32m, .lp_osc_select);
  always #2.5 pclk = ~pclk;
  // Oscillator square wave, 8 pclk period so high and low each last 4 pclk
  always begin
    repeat (4) @(posedge pclk);
    aclk_hs_tick <= ~aclk_hs_tick;
    aclk_lp_tick <= ~aclk_lp_tick;
  end
  //////////////////////////////////////////////////////////////////////////////
  // Waits an edge first so a release and the next setup never share a step
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait on the slave
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [15:0] a, input logic [31:0] ex);
    apb(1'b0, a, '0);
    `CHK("read data", ex, rdat)
  endtask
  task automatic load2();
    int n;
    repeat (2) begin
      n = 0;
      do begin @(posedge pclk); n++; end while (converter_load !== 1'b1 && n < 300);
      if (n >= 300) n_mismatch++;
    end
  endtask
  task automatic outc(input logic [11:0] ex);
    load2();
    `CHK("converter code", ex, converter_code)
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rdc(excitation_dac_pkg::ADDR_CONFIG, 32'h0000001E);
    rdc(excitation_dac_pkg::ADDR_CODE, 32'h00000800);
    rdc(excitation_dac_pkg::ADDR_LOCK, 32'hDE87A5A0);
    rdc(excitation_dac_pkg::ADDR_GAIN, 32'h00000800);
    rdc(excitation_dac_pkg::ADDR_OFS_ATT_HS, 32'h0);
    `CHK("gain select", 1'b0, amp_gain_select)
    `CHK("attenuator", 1'b0, attenuator_enable)
    `CHK("converter code", 12'h800, converter_code)
  endtask
  // A reset in mid-run must bring config, code, lock, gain, high speed attenuated offset and clock select back to reset values
  task automatic t_rerun();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    rdc(excitation_dac_pkg::ADDR_CLK_SEL, 32'h0);
  endtask
  task automatic t_config();
    apb(1'b1, excitation_dac_pkg::ADDR_CONFIG, 32'hFFFFFFFF);
    rdc(excitation_dac_pkg::ADDR_CONFIG, 32'h00001FFF);
    `CHK("gain select", 1'b1, amp_gain_select)
    `CHK("attenuator", 1'b1, attenuator_enable)
    apb(1'b1, excitation_dac_pkg::ADDR_CONFIG, 32'h2);
    apb(1'b1, 16'h2000, 32'h1);
    `CHK("slave error", 1'b1, rerr)
  endtask
  // Trims refuse writes until the key is in place
  task automatic t_lock();
    apb(1'b1, excitation_dac_pkg::ADDR_GAIN, 32'h123);
    rdc(excitation_dac_pkg::ADDR_GAIN, 32'h800);
    apb(1'b1, excitation_dac_pkg::ADDR_LOCK, 32'hDE87A5AF);
    apb(1'b1, excitation_dac_pkg::ADDR_GAIN, 32'hFFFFF123);
    rdc(excitation_dac_pkg::ADDR_GAIN, 32'h123);
    apb(1'b1, excitation_dac_pkg::ADDR_GAIN, 32'h800);
    // Any other lock value closes the trims again
    apb(1'b1, excitation_dac_pkg::ADDR_LOCK, 32'h0);
    apb(1'b1, excitation_dac_pkg::ADDR_GAIN, 32'h555);
    rdc(excitation_dac_pkg::ADDR_GAIN, 32'h800);
    apb(1'b1, excitation_dac_pkg::ADDR_LOCK, 32'hDE87A5AF);
  endtask
  task automatic t_code();
    // Codes stay inside the usable span
    logic [11:0] c[3] = '{12'h200, 12'h800, 12'hE00};
    foreach (c[i]) begin
      apb(1'b1, excitation_dac_pkg::ADDR_CODE, {20'h0, c[i]});
      outc(c[i]);
      rdc(excitation_dac_pkg::ADDR_STATUS, {19'h0, 1'b1, c[i]});
    end
  endtask
  task automatic t_rate();
    int cnt;
    for (int n = 1; n <= 3; n++) begin
      apb(1'b1, excitation_dac_pkg::ADDR_CONFIG, 32'(n) << 1);
      load2();
      cnt = 0;
      do begin @(posedge pclk); cnt++; end while (converter_load !== 1'b1 && cnt < 500);
      `CHK("update spacing", 8 * n, cnt)
    end
    apb(1'b1, excitation_dac_pkg::ADDR_CONFIG, 32'h2);
  endtask
  task automatic t_trim();
    apb(1'b1, excitation_dac_pkg::ADDR_OFS_PLAIN_LP, 32'h2);
    apb(1'b1, excitation_dac_pkg::ADDR_OFS_ATT_HS, 32'h4);
    apb(1'b1, excitation_dac_pkg::ADDR_CODE, 32'h345);
    outc(12'h346);
    high_speed_mode <= 1'b1;
    outc(12'h345);
    apb(1'b1, excitation_dac_pkg::ADDR_CONFIG, 32'h3);
    outc(12'h347);
    high_speed_mode <= 1'b0;
    outc(12'h345);
    apb(1'b1, excitation_dac_pkg::ADDR_GAIN, 32'hC00);
    apb(1'b1, excitation_dac_pkg::ADDR_CODE, 32'hC00);
    outc(12'hC40);
    apb(1'b1, excitation_dac_pkg::ADDR_CONFIG, 32'h2);
    outc(12'hC41);
  endtask
  // Select 3 is folded onto the low power oscillator
  task automatic t_clk();
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, excitation_dac_pkg::ADDR_CLK_SEL, 32'(s));
      repeat (3) @(posedge pclk);
      `CHK("osc 32m", s == 1, hs_osc_32m)
      `CHK("osc low power", s >= 2, lp_osc_select)
    end
    rdc(excitation_dac_pkg::ADDR_CLK_SEL, 32'h2);
    outc(12'hC41);
  endtask
  task automatic summarize();
    if (n_mismatch == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_config();
    t_lock();
    t_code();
    t_rate();
    t_trim();
    t_clk();
    t_rerun();
    summarize();
  end
  initial begin
    #200000;
    n_mismatch++;
    summarize();
  end
endmodule
`default_nettype wire
